// file: ibdcc_defs.svh
// Timing constants and channel layout of the ISA cycle and DMA handshake block
`ifndef IBDCC_DEFS_SVH
`define IBDCC_DEFS_SVH

// Core clock period in ns
`define IBDCC_CLK_NS 8
// ISA system clock period in ns, derived from the core clock
`define IBDCC_SYSCLK_NS 128
// Core clocks per half ISA clock period, a longest time so it rounds down
`define IBDCC_HALF_CYCLES ((`IBDCC_SYSCLK_NS / 2) / `IBDCC_CLK_NS)
// Command strobe length in half ISA clocks when no zero-wait ends it early
`define IBDCC_CMD_HALVES 8
// Refresh strobe length in half ISA clocks
`define IBDCC_REF_HALVES 6
// Number of DMA channels: 7..5 on bits 6..4, 3..0 on bits 3..0
`define IBDCC_NCH 7
// Address bit where the first megabyte ends
`define IBDCC_MEG_BIT 20
// Synchroniser layout
`define IBDCC_SY_OWN_ACK 7
`define IBDCC_SY_ZWS 8
`define IBDCC_SY_PAR 9
`define IBDCC_SY_STRB 10
`define IBDCC_SY_W 15

`endif

// file: ibdcc_pkg.sv
// Types of the ISA cycle and DMA handshake block
package ibdcc_pkg;

    typedef enum logic [1:0] {
        IBDCC_MEM_RD,
        IBDCC_MEM_WR,
        IBDCC_IO_RD,
        IBDCC_IO_WR
    } ibdcc_cmd_t;

    typedef enum logic [2:0] {
        IBDCC_IDLE,
        IBDCC_ALE,
        IBDCC_CMD,
        IBDCC_REF
    } ibdcc_state_t;

    // The five shared ISA strobes, all active low
    typedef struct packed {
        logic isa_mem_read_n;
        logic isa_mem_write_n;
        logic isa_io_read_n;
        logic isa_io_write_n;
        logic isa_refresh_n;
    } ibdcc_strb_t;

    typedef struct packed {
        logic [14:0] sy1;
        logic [14:0] sy2;
        logic [3:0] half_cnt;
        logic sysclk;
        ibdcc_state_t state;
        logic [3:0] cnt;
        logic ref_pend;
        logic low_meg;
        ibdcc_strb_t strb;
        ibdcc_strb_t strb_pin;
        ibdcc_strb_t strb_oe_n;
        ibdcc_strb_t strb_seen;
        logic low_meg_read_n;
        logic low_meg_write_n;
        logic ale;
        logic aen;
        logic pci_own_req_n;
        logic [6:0] dma_ack_n;
        logic granted;
        logic [2:0] gch;
        logic tc;
        logic nmi;
        logic cmd_ready;
        logic cmd_done;
    } ibdcc_reg_t;

endpackage

// file: ibdcc_top.sv
// ISA command strobes, address latch, ISA clock and DMA ownership handshake
// ============================================================
`timescale 1ns/10ps
`include "ibdcc_defs.svh"

module ibdcc_top
    import ibdcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Processor-to-ISA command port, core clock domain
    input wire logic cmd_req,
    input wire ibdcc_cmd_t cmd_type,
    input wire logic [23:0] cmd_addr,
    output logic cmd_ready,
    output logic cmd_done,
    // Refresh and other bus-master requests, core clock domain
    input wire logic refresh_req,
    input wire logic isa_master_cycle,
    input wire logic ide_dma_req,
    input wire logic usb_master_req,
    input wire logic dma_xfer_done,
    // ISA strobes, five signals each
    input wire ibdcc_strb_t strb_in,
    output ibdcc_strb_t strb_out,
    output ibdcc_strb_t strb_oe_n,
    output ibdcc_strb_t strb_seen,
    // ISA address and clock pins
    output logic low_meg_read_n,
    output logic low_meg_write_n,
    output logic addr_latch_en,
    output logic addr_en,
    output logic isa_sysclk,
    input wire logic zero_wait_n,
    input wire logic isa_parity_err_n,
    output logic nmi,
    // DMA and PCI ownership pins
    input wire logic [6:0] dma_req,
    output logic [6:0] dma_ack_n,
    output logic dma_tc,
    output logic pci_own_req_n,
    input wire logic pci_own_ack_n
);

    localparam logic [3:0] HALF_CYC = 4'(`IBDCC_HALF_CYCLES);
    localparam logic [3:0] CMD_HALVES = 4'(`IBDCC_CMD_HALVES);
    localparam logic [3:0] REF_HALVES = 4'(`IBDCC_REF_HALVES);
    localparam ibdcc_strb_t STRB_IDLE = 5'h1f;

    ibdcc_reg_t r_q;
    ibdcc_reg_t r_d;

    logic tick;
    logic own_ack;
    logic zws;
    logic [6:0] req_s;
    logic any_req;
    logic [2:0] pick;
    logic pick_ok;
    logic start_cmd;

    // Lowest numbered pending channel wins
    always_comb
    begin
        pick = 3'h0;
        pick_ok = 1'b0;
        for (int i = `IBDCC_NCH - 1; i >= 0; i--)
        begin
            if (req_s[i])
            begin
                pick = 3'(i);
                pick_ok = 1'b1;
            end
        end
    end

    always_comb
    begin
        r_d = r_q;
        // Only the second stage is read by any logic
        r_d.sy1 = {strb_in, isa_parity_err_n, zero_wait_n, pci_own_ack_n, dma_req};
        r_d.sy2 = r_q.sy1;
        req_s = r_q.sy2[6:0];
        own_ack = ~r_q.sy2[`IBDCC_SY_OWN_ACK];
        zws = ~r_q.sy2[`IBDCC_SY_ZWS];
        any_req = (|req_s) | ide_dma_req | usb_master_req | isa_master_cycle;
        r_d.cmd_done = 1'b0;
        r_d.tc = 1'b0;

        // Half-period counter makes the ISA clock
        tick = (r_q.half_cnt == 4'h0);
        if (tick)
        begin
            r_d.half_cnt = HALF_CYC - 4'h1;
            r_d.sysclk = ~r_q.sysclk;
        end
        else
        begin
            r_d.half_cnt = r_q.half_cnt - 4'h1;
        end

        r_d.nmi = ~r_q.sy2[`IBDCC_SY_PAR];
        r_d.pci_own_req_n = ~(any_req | r_q.granted);

        // A refresh request landing while one is taken is kept
        r_d.ref_pend = refresh_req | r_q.ref_pend;

        // DMA grant only from idle with no refresh pending; a command taken in the same cycle still starts
        if (r_q.granted)
        begin
            if (!req_s[r_q.gch])
            begin
                r_d.granted = 1'b0;
                r_d.dma_ack_n = 7'h7f;
            end
            else if (dma_xfer_done)
            begin
                r_d.tc = 1'b1;
            end
        end
        else if (own_ack && pick_ok && r_q.state == IBDCC_IDLE && !r_q.ref_pend)
        begin
            r_d.granted = 1'b1;
            r_d.gch = pick;
            r_d.dma_ack_n = ~(7'h01 << pick);
        end

        start_cmd = cmd_req && r_q.cmd_ready && !isa_master_cycle;

        case (r_q.state)
            IBDCC_IDLE:
            begin
                if (r_q.ref_pend && !r_q.granted && !isa_master_cycle)
                begin
                    r_d.ref_pend = refresh_req;
                    r_d.state = IBDCC_REF;
                    r_d.cnt = REF_HALVES;
                    r_d.strb.isa_refresh_n = 1'b0;
                    r_d.strb.isa_mem_read_n = 1'b0;
                end
                else if (start_cmd)
                begin
                    r_d.state = IBDCC_ALE;
                    r_d.cnt = CMD_HALVES;
                    r_d.low_meg = (cmd_addr[23:`IBDCC_MEG_BIT] == 4'h0);
                    r_d.strb = STRB_IDLE;
                    case (cmd_type)
                        IBDCC_MEM_RD: r_d.strb.isa_mem_read_n = 1'b0;
                        IBDCC_MEM_WR: r_d.strb.isa_mem_write_n = 1'b0;
                        IBDCC_IO_RD: r_d.strb.isa_io_read_n = 1'b0;
                        default: r_d.strb.isa_io_write_n = 1'b0;
                    endcase
                end
            end
            IBDCC_ALE:
            begin
                // Strobe pattern is held internally until the latch half-period ends
                if (tick)
                begin
                    r_d.state = IBDCC_CMD;
                end
            end
            IBDCC_CMD:
            begin
                if (zws || (tick && r_q.cnt == 4'h1))
                begin
                    r_d.state = IBDCC_IDLE;
                    r_d.strb = STRB_IDLE;
                    r_d.cmd_done = 1'b1;
                end
                else if (tick)
                begin
                    r_d.cnt = r_q.cnt - 4'h1;
                end
            end
            IBDCC_REF:
            begin
                if (tick && r_q.cnt == 4'h1)
                begin
                    r_d.state = IBDCC_IDLE;
                    r_d.strb = STRB_IDLE;
                end
                else if (tick)
                begin
                    r_d.cnt = r_q.cnt - 4'h1;
                end
            end
            default:
            begin
                r_d.state = IBDCC_IDLE;
                r_d.strb = STRB_IDLE;
            end
        endcase

        // Command strobes reach the pins only once the command phase begins, refresh strobes at once
        r_d.strb_pin = (r_d.state == IBDCC_ALE) ? STRB_IDLE : r_d.strb;
        r_d.strb_oe_n = isa_master_cycle ? STRB_IDLE : 5'h00;
        r_d.strb_seen = r_q.sy2[`IBDCC_SY_W-1:`IBDCC_SY_STRB] | ~r_q.strb_oe_n;
        r_d.low_meg_read_n = !(r_d.state == IBDCC_CMD && r_d.low_meg
            && !r_d.strb.isa_mem_read_n);
        r_d.low_meg_write_n = !(r_d.state == IBDCC_CMD && r_d.low_meg
            && !r_d.strb.isa_mem_write_n);
        r_d.aen = r_d.granted;
        r_d.ale = r_d.granted || isa_master_cycle || r_d.state == IBDCC_REF
            || r_d.state == IBDCC_ALE;
        // Taking commands only on a half-period boundary keeps the latch pulse a full half clock
        r_d.cmd_ready = (r_d.state == IBDCC_IDLE) && !r_d.granted && !r_d.ref_pend
            && !start_cmd && (r_d.half_cnt == 4'h0);
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            r_q <= '0;
            r_q.sy1 <= 15'h7fff;
            r_q.sy2 <= 15'h7fff;
            r_q.state <= IBDCC_IDLE;
            r_q.strb <= STRB_IDLE;
            r_q.strb_pin <= STRB_IDLE;
            r_q.strb_oe_n <= STRB_IDLE;
            r_q.strb_seen <= STRB_IDLE;
            r_q.low_meg_read_n <= 1'b1;
            r_q.low_meg_write_n <= 1'b1;
            r_q.pci_own_req_n <= 1'b1;
            r_q.dma_ack_n <= 7'h7f;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // Pins driven straight from the state register
    assign cmd_ready = r_q.cmd_ready;
    assign cmd_done = r_q.cmd_done;
    assign strb_out = r_q.strb_pin;
    assign strb_oe_n = r_q.strb_oe_n;
    assign strb_seen = r_q.strb_seen;
    assign low_meg_read_n = r_q.low_meg_read_n;
    assign low_meg_write_n = r_q.low_meg_write_n;
    assign addr_latch_en = r_q.ale;
    assign addr_en = r_q.aen;
    assign isa_sysclk = r_q.sysclk;
    assign nmi = r_q.nmi;
    assign dma_ack_n = r_q.dma_ack_n;
    assign dma_tc = r_q.tc;
    assign pci_own_req_n = r_q.pci_own_req_n;

endmodule

// file: ibdcc_monitor.sv
// Port assertions for the ISA cycle and DMA handshake block
`timescale 1ns/10ps
module ibdcc_monitor
    import ibdcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Observed ports
    input wire logic cmd_done,
    input wire logic isa_master_cycle,
    input wire logic dma_xfer_done,
    input wire ibdcc_strb_t strb_out,
    input wire ibdcc_strb_t strb_oe_n,
    input wire logic addr_latch_en,
    input wire logic addr_en,
    input wire logic isa_sysclk,
    input wire logic zero_wait_n,
    input wire logic isa_parity_err_n,
    input wire logic nmi,
    input wire logic [6:0] dma_ack_n,
    input wire logic dma_tc,
    input wire logic pci_own_ack_n
);
    // ========================================
    // Properties
    logic cmd_low;
    logic granted;
    assign cmd_low = !(&strb_out[4:1]) && strb_out.isa_refresh_n;
    assign granted = !(&dma_ack_n);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    strobe_release_a: assert property (isa_master_cycle |=> strb_oe_n == 5'h1f)
        else $error("strobes driven in master cycle");
    dma_aen_a: assert property (granted |-> addr_en)
        else $error("address enable low during grant");
    zero_wait_a: assert property (cmd_low && !zero_wait_n |-> ##[1:4] cmd_done)
        else $error("zero wait did not end command");
    parity_nmi_a: assert property ($fell(isa_parity_err_n) |-> ##[2:4] nmi)
        else $error("no nmi after parity error");
    sysclk_period_a: assert property ($changed(isa_sysclk) |=>
        !$changed(isa_sysclk) [*7] ##1 $changed(isa_sysclk))
        else $error("isa clock half period wrong");
    ale_hold_a: assert property (granted || !strb_out.isa_refresh_n |-> addr_latch_en)
        else $error("latch enable dropped in long cycle");
    ale_short_a: assert property ($rose(cmd_low) |-> $past(addr_latch_en) && !addr_latch_en)
        else $error("latch enable not ended at strobe");
    ale_length_a: assert property ($rose(addr_latch_en) && !granted
        && strb_out.isa_refresh_n && !$past(isa_master_cycle)
        |-> addr_latch_en [*8] ##1 (!addr_latch_en && cmd_low))
        else $error("latch enable not a half clock");
    master_ale_a: assert property (isa_master_cycle |=> addr_latch_en)
        else $error("latch enable low in master cycle");
    ack_after_own_a: assert property ($rose(granted) |-> !$past(pci_own_ack_n))
        else $error("dma ack without ownership");
    one_grant_a: assert property ($onehot0(~dma_ack_n))
        else $error("more than one dma ack");
    tc_pulse_a: assert property (dma_xfer_done && granted |=> dma_tc ##1 !dma_tc)
        else $error("end of process pulse wrong");
    cover property (cmd_done);
    cover property ($rose(granted));
    cover property (!strb_out.isa_refresh_n);
endmodule

bind ibdcc_top ibdcc_monitor u_mon (.clk, .resetn, .cmd_done, .isa_master_cycle,
    .dma_xfer_done, .strb_out, .strb_oe_n, .addr_latch_en, .addr_en, .isa_sysclk,
    .zero_wait_n, .isa_parity_err_n, .nmi, .dma_ack_n, .dma_tc, .pci_own_ack_n);

// file: ibdcc_slot_model.sv
// Far side: strobe pull-ups, ISA target zero-wait and PCI arbiter
`timescale 1ns/10ps
module ibdcc_slot_model
    import ibdcc_pkg::*;
(
    // Clock and modes
    input wire logic clk,
    input wire logic fast,
    input wire logic slow_arb,
    // Device pins
    input wire ibdcc_strb_t strb_out,
    input wire ibdcc_strb_t strb_oe_n,
    input wire ibdcc_strb_t ext_strb,
    input wire logic pci_own_req_n,
    output ibdcc_strb_t strb_in,
    output logic zero_wait_n = 1'h1,
    output logic pci_own_ack_n = 1'h1
);
    logic [3:0] lag_q = 4'hf;
    // Released strobes float to their pull-ups unless an external master pulls them
    assign strb_in = (strb_out | strb_oe_n) & (ext_strb | ~strb_oe_n);
    always @(negedge clk)
    begin
        zero_wait_n <= !(fast && !(&strb_in[4:1]) && strb_in[0]);
        lag_q <= {lag_q[2:0], pci_own_req_n};
        pci_own_ack_n <= slow_arb ? lag_q[3] : pci_own_req_n;
    end
endmodule

// file: isa_bus_dma_cycle_control_test.sv
// Self-checking bench for the ISA cycle and DMA handshake block
`timescale 1ns/10ps
module isa_bus_dma_cycle_control_test
    import ibdcc_pkg::*;
;
    logic clk = 1'h0, resetn = 1'h0, cmd_req = 1'h0, refresh_req = 1'h0, isa_master_cycle = 1'h0;
    logic ide_dma_req = 1'h0, usb_master_req = 1'h0, dma_xfer_done = 1'h0, fast = 1'h0;
    logic isa_parity_err_n = 1'h1, slow = 1'h0, lm_seen = 1'h0;
    ibdcc_cmd_t cmd_type = IBDCC_MEM_RD;
    logic [23:0] cmd_addr = 24'h0;
    logic [6:0] dma_req = 7'h0, prev_ack = 7'h7f, dma_ack_n, m, e, got;
    logic cmd_ready, cmd_done, low_meg_read_n, low_meg_write_n, addr_latch_en, addr_en;
    logic isa_sysclk, zero_wait_n, nmi, dma_tc, pci_own_req_n, pci_own_ack_n;
    ibdcc_strb_t strb_in, strb_out, strb_oe_n, strb_seen, ext_strb = 5'h1f;
    logic [6:0] exp_q[$];
    int error_cnt = 0, tests_run = 0, len = 0;

    ibdcc_top u_dut (.clk, .resetn, .cmd_req, .cmd_type, .cmd_addr, .cmd_ready, .cmd_done,
        .refresh_req, .isa_master_cycle, .ide_dma_req, .usb_master_req, .dma_xfer_done,
        .strb_in, .strb_out, .strb_oe_n, .strb_seen, .low_meg_read_n, .low_meg_write_n,
        .addr_latch_en, .addr_en, .isa_sysclk, .zero_wait_n, .isa_parity_err_n, .nmi,
        .dma_req, .dma_ack_n, .dma_tc, .pci_own_req_n, .pci_own_ack_n);
    ibdcc_slot_model u_far (.clk, .fast, .slow_arb(slow), .strb_out, .strb_oe_n, .ext_strb,
        .pci_own_req_n, .strb_in, .zero_wait_n, .pci_own_ack_n);

    always #4 clk = ~clk;

    task automatic chk(input string n, input logic [6:0] x, input logic [6:0] s);
        tests_run++;
        if (x !== s)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ========================================
    // Result watcher: command length class, low-meg strobe, new grant
    always @(negedge clk)
    begin
        if (!(&strb_out[4:1]) && strb_out.isa_refresh_n)
            len++;
        lm_seen |= !(low_meg_read_n && low_meg_write_n);
        if (cmd_done === 1'h1 || (&prev_ack && !(&dma_ack_n)))
        begin
            got = cmd_done ? {5'h0, lm_seen, 1'(len > 62 && len < 66)} : ~dma_ack_n;
            chk("result", exp_q.size() > 0 ? exp_q.pop_front() : 7'h7f, got);
            len = 0;
            lm_seen = 1'h0;
        end
        prev_ack = dma_ack_n;
    end

    // ========================================
    // Stimulus
    initial
    begin
        int k;
        void'($urandom(38));
        cyc(6);
        resetn = 1'h1;
        cyc(2);
        chk("ack_rst", 7'h7f, dma_ack_n);
        // Each type, both address classes, slow and zero-wait target
        for (int i = 0; i < 16; i++)
        begin
            for (k = 0; k < 300 && cmd_ready !== 1'h1; k++) cyc(1);
            fast = i[3];
            cmd_type = ibdcc_cmd_t'(i[1:0]);
            cmd_addr = {3'h0, i[2], 20'($urandom)};
            exp_q.push_back({5'h0, 1'(!i[1] && !i[2]), 1'(!i[3])});
            cmd_req = 1'h1;
            cyc(1);
            cmd_req = 1'h0;
            for (k = 0; k < 300 && cmd_done !== 1'h1; k++) cyc(1);
        end
        refresh_req = 1'h1;
        cyc(1);
        refresh_req = 1'h0;
        for (k = 0; k < 300 && strb_out.isa_refresh_n !== 1'h0; k++) cyc(1);
        chk("ale_ref", 7'h1, 7'(addr_latch_en));
        for (k = 0; k < 300 && strb_out.isa_refresh_n !== 1'h1; k++) cyc(1);
        // External master drives its own strobe pattern; it must come back synced
        isa_master_cycle = 1'h1;
        ext_strb = 5'($urandom);
        cyc(4);
        chk("oe_master", 7'h1f, 7'(strb_oe_n));
        chk("ale_master", 7'h1, 7'(addr_latch_en));
        chk("seen", 7'(ext_strb), 7'(strb_seen));
        isa_master_cycle = 1'h0;
        ext_strb = 5'h1f;
        cyc(2);
        chk("oe_owner", 7'h0, 7'(strb_oe_n));
        // Several channels at once; served lowest first, arbiter alternates speed
        slow = 1'h1;
        m = 7'($urandom) | 7'h41;
        dma_req = m;
        while (m != 7'h0)
        begin
            e = m & (~m + 7'h1);
            exp_q.push_back(e);
            for (k = 0; k < 300 && &dma_ack_n; k++) cyc(1);
            chk("aen", 7'h1, 7'(addr_en));
            dma_xfer_done = 1'h1;
            cyc(1);
            dma_xfer_done = 1'h0;
            chk("tc", 7'h1, 7'(dma_tc));
            m = m & ~e;
            dma_req = m;
            for (k = 0; k < 300 && !(&dma_ack_n); k++) cyc(1);
            slow = !slow;
        end
        for (int j = 0; j < 3; j++)
        begin
            {usb_master_req, ide_dma_req, isa_master_cycle} = 3'h1 << j;
            cyc(5);
            chk("own_req", 7'h0, 7'(pci_own_req_n));
            {usb_master_req, ide_dma_req, isa_master_cycle} = 3'h0;
            cyc(6);
            chk("own_rel", 7'h1, 7'(pci_own_req_n));
        end
        isa_parity_err_n = 1'h0;
        cyc(4);
        chk("nmi", 7'h1, 7'(nmi));
        isa_parity_err_n = 1'h1;
        cyc(4);
        chk("nmi_off", 7'h0, 7'(nmi));
        // A result that never appeared leaves its note behind
        chk("pending", 7'h0, 7'(exp_q.size()));
        stop_test();
    end

    initial
    begin
        #(20000 * 8);
        error_cnt++;
        stop_test();
    end
endmodule
